// ---- hdl/srdc_host.sv ----
// Host controller that frames and shifts commands into a chain of serial converters
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module srdc_host (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic [31:0]      HRDATA,
    output logic             SER_CLK,
    output logic             SER_DOUT,
    output logic             SER_LATCH,
    input  wire logic        SER_DIN
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        logic                        wr_pend;   // Write data phase pending
        logic [7:0]                  wr_addr;   // Latched write address
        logic [31:0]                 rdata;     // Read data for the data phase
        logic                        readback;  // Two-frame readback sequence
        logic [1:0]                  len_m1;    // Devices in chain minus one
        logic                        done;      // Sticky sequence complete
        logic [3:0][23:0]            tx;        // Outgoing words, index 0 nearest
        logic [3:0][23:0]            rx;        // Returned words, index 0 nearest
        srdc_pkg::srdc_state_t       state;
        logic [3:0]                  tmr;       // Half period timer
        logic [6:0]                  bits;      // Clocks issued in this frame
        logic                        second;    // Now sending the idle frame
        logic [95:0]                 shreg;     // Outgoing frame, MSB leaves first
        logic [3:0][23:0]            rxsh;      // Incoming bits, last bit lowest
        srdc_pkg::srdc_pins_t        pins;
        logic [1:0]                  din_sync;  // Two-flop synchroniser on SER_DIN
    } srdc_regs_t;

    srdc_regs_t        s_r;
    srdc_regs_t        s_nxt;
    srdc_pkg::srdc_ahb_t bus;
    logic [6:0]        frame_len;
    logic              addr_ok;
    logic              start_req;

    // ------------------------------------------------------------
    // Frame helpers
    // ------------------------------------------------------------

    // Places the farthest device's word at the top of the frame
    function automatic logic [95:0] srdc_pack(input logic [3:0][23:0] w,
                                              input logic [1:0]       len_m1);
        logic [95:0] flat;
        flat = w;
        srdc_pack = flat << (7'(2'h3 - len_m1) * srdc_pkg::FRAME_BITS);
    endfunction : srdc_pack

    // Builds one read request word from the select code in a TX word
    function automatic logic [23:0] srdc_rdreq(input logic [23:0] w);
        srdc_rdreq = {srdc_pkg::CMD_READ, srdc_pkg::READ_PAD,
                      w[srdc_pkg::SEL_W-1:0]};
    endfunction : srdc_rdreq

    // Register read multiplexer, unmapped offsets read as zero
    function automatic logic [31:0] srdc_rd(input srdc_regs_t s, input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == srdc_pkg::OFS_CTRL) begin
            v[srdc_pkg::CTRL_RDBK]                     = s.readback;
            v[srdc_pkg::CTRL_LEN_LO+1:srdc_pkg::CTRL_LEN_LO] = s.len_m1;
        end else if (a == srdc_pkg::OFS_STAT) begin
            v[srdc_pkg::STAT_BUSY] = (s.state != srdc_pkg::SRDC_IDLE);
            v[srdc_pkg::STAT_DONE] = s.done;
        end else if (a[7:4] == srdc_pkg::OFS_TX0[7:4]) begin
            v[23:0] = s.tx[a[3:2]];
        end else if (a[7:4] == srdc_pkg::OFS_RX0[7:4]) begin
            v[23:0] = s.rx[a[3:2]];
        end
        srdc_rd = v;
    endfunction : srdc_rd

    // ------------------------------------------------------------
    // Bus group and derived terms
    // ------------------------------------------------------------

    // Gather the bus request; low address byte decodes, word aligned
    assign bus       = '{HSEL, HADDR, HTRANS, HWRITE, HSIZE, HWDATA, HREADY};
    assign addr_ok   = bus.sel && bus.ready && bus.trans == srdc_pkg::HTRANS_NSEQ;
    assign frame_len = 7'(({5'h00, s_r.len_m1} + 7'h01) * srdc_pkg::FRAME_BITS);

    // Start is honoured only from idle; a start while busy is dropped
    assign start_req = s_r.wr_pend && s_r.wr_addr == srdc_pkg::OFS_CTRL
                       && bus.wdata[srdc_pkg::CTRL_START]
                       && s_r.state == srdc_pkg::SRDC_IDLE;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        // Synchroniser: first flop feeds only the second
        s_nxt.din_sync = {s_r.din_sync[0], SER_DIN};

        // Address phase: capture write target, prepare read data
        s_nxt.wr_pend = 1'b0;
        if (addr_ok) begin
            s_nxt.wr_pend = bus.write;
            s_nxt.wr_addr = {bus.addr[7:2], 2'h0};
            if (!bus.write) begin
                s_nxt.rdata = srdc_rd(s_r, {bus.addr[7:2], 2'h0});
            end
        end

        // Data phase of a write; mode bits are frozen while a sequence runs
        if (s_r.wr_pend) begin
            if (s_r.wr_addr == srdc_pkg::OFS_CTRL) begin
                if (s_r.state == srdc_pkg::SRDC_IDLE) begin
                    s_nxt.readback = bus.wdata[srdc_pkg::CTRL_RDBK];
                    s_nxt.len_m1   = bus.wdata[srdc_pkg::CTRL_LEN_LO+1:srdc_pkg::CTRL_LEN_LO];
                end
            end else if (s_r.wr_addr == srdc_pkg::OFS_STAT) begin
                if (bus.wdata[srdc_pkg::STAT_DONE]) begin
                    s_nxt.done = 1'b0;
                end
            end else if (s_r.wr_addr[7:4] == srdc_pkg::OFS_TX0[7:4]) begin
                s_nxt.tx[s_r.wr_addr[3:2]] = bus.wdata[23:0];
            end
        end

        // Frame sequencer
        case (s_r.state)
            srdc_pkg::SRDC_IDLE: begin
                s_nxt.pins = '0;
                if (start_req) begin
                    s_nxt.second = 1'b0;
                    s_nxt.state  = srdc_pkg::SRDC_LOAD;
                end
            end
            srdc_pkg::SRDC_LOAD: begin
                // Readback sends requests then idle words; plain mode sends raw words
                if (s_r.second) begin
                    s_nxt.shreg = '0;
                end else if (s_r.readback) begin
                    s_nxt.shreg = srdc_pack({srdc_rdreq(s_r.tx[3]), srdc_rdreq(s_r.tx[2]),
                                             srdc_rdreq(s_r.tx[1]), srdc_rdreq(s_r.tx[0])},
                                            s_r.len_m1);
                end else begin
                    s_nxt.shreg = srdc_pack(s_r.tx, s_r.len_m1);
                end
                s_nxt.pins.mosi  = s_nxt.shreg[95];
                s_nxt.pins.sclk  = 1'b0;
                s_nxt.pins.latch = 1'b0;
                s_nxt.bits       = 7'h00;
                s_nxt.tmr        = 4'h0;
                s_nxt.state      = srdc_pkg::SRDC_LOW;
            end
            srdc_pkg::SRDC_LOW: begin
                s_nxt.tmr = s_r.tmr + 4'h1;
                if (s_r.tmr == srdc_pkg::HALF_LAST) begin
                    // Rising edge: device takes our bit, we take its bit
                    s_nxt.pins.sclk = 1'b1;
                    s_nxt.rxsh      = {s_r.rxsh[3][22:0], s_r.rxsh[2:0], s_r.din_sync[1]};
                    s_nxt.tmr       = 4'h0;
                    s_nxt.state     = srdc_pkg::SRDC_HIGH;
                end
            end
            srdc_pkg::SRDC_HIGH: begin
                s_nxt.tmr = s_r.tmr + 4'h1;
                if (s_r.tmr == srdc_pkg::HALF_LAST) begin
                    // Falling edge: present the next bit while the clock is low
                    s_nxt.pins.sclk = 1'b0;
                    s_nxt.shreg     = {s_r.shreg[94:0], 1'b0};
                    s_nxt.pins.mosi = s_r.shreg[94];
                    s_nxt.bits      = s_r.bits + 7'h01;
                    s_nxt.tmr       = 4'h0;
                    if (s_r.bits + 7'h01 == frame_len) begin
                        // Latch only after the last clock of an exact burst
                        s_nxt.pins.mosi  = 1'b0;
                        s_nxt.pins.latch = 1'b1;
                        s_nxt.state      = srdc_pkg::SRDC_LATCH;
                    end else begin
                        s_nxt.state = srdc_pkg::SRDC_LOW;
                    end
                end
            end
            srdc_pkg::SRDC_LATCH: begin
                // Latch high commits every device in the chain together
                s_nxt.tmr = s_r.tmr + 4'h1;
                if (s_r.tmr == srdc_pkg::HALF_LAST) begin
                    s_nxt.pins.latch = 1'b0;
                    s_nxt.tmr        = 4'h0;
                    s_nxt.state      = srdc_pkg::SRDC_GAP;
                end
            end
            srdc_pkg::SRDC_GAP: begin
                // Clock is stopped here; gated bursts are legal for the device
                s_nxt.tmr = s_r.tmr + 4'h1;
                if (s_r.tmr == srdc_pkg::HALF_LAST) begin
                    s_nxt.tmr = 4'h0;
                    if (s_r.readback && !s_r.second) begin
                        s_nxt.second = 1'b1;
                        s_nxt.state  = srdc_pkg::SRDC_LOAD;
                    end else begin
                        // Plain frames return what the chain held before
                        s_nxt.rx    = s_r.rxsh;
                        s_nxt.state = srdc_pkg::SRDC_IDLE;
                    end
                end
            end
            default: begin
                s_nxt.pins  = '0;
                s_nxt.state = srdc_pkg::SRDC_IDLE;
            end
        endcase

        // Completion set placed last so it wins over a same-cycle clear
        if (s_r.state == srdc_pkg::SRDC_GAP && s_r.tmr == srdc_pkg::HALF_LAST
            && !(s_r.readback && !s_r.second)) begin
            s_nxt.done = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Asynchronous reset loads constants only
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r       <= '0;
            s_r.state <= srdc_pkg::SRDC_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Zero wait states, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = s_r.rdata;
    assign SER_CLK   = s_r.pins.sclk;
    assign SER_DOUT  = s_r.pins.mosi;
    assign SER_LATCH = s_r.pins.latch;

endmodule : srdc_host

// ---- include/srdc_pkg.sv ----
// Shared constants, states and carrier types of the serial chain host controller
package srdc_pkg;

    // ------------------------------------------------------------
    // Frame layout and device command codes
    // ------------------------------------------------------------
    localparam int unsigned     CHAIN_MAX    = 4;        // Deepest chain the frame buffer holds
    localparam logic [6:0]      FRAME_BITS   = 7'h18;    // 24 clocks per device
    localparam logic [7:0]      CMD_IDLE     = 8'h00;    // idle_command
    localparam logic [7:0]      CMD_READ     = 8'h02;    // Readback request
    localparam logic [9:0]      READ_PAD     = 10'h000;  // Ignored upper data bits
    localparam int unsigned     SEL_W        = 6;        // Width of the read select code

    // ------------------------------------------------------------
    // Serial timing: half period of the generated link clock
    // ------------------------------------------------------------
    localparam int unsigned     CLK_MHZ      = 25;
    localparam int unsigned     HALF_NS      = 160;      // Least half period, rounded up
    localparam int unsigned     HALF_CYC     = (HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0]      HALF_LAST    = 4'(HALF_CYC - 1);

    // ------------------------------------------------------------
    // Controller register map (byte addresses, low address byte)
    // ------------------------------------------------------------
    localparam logic [7:0]      OFS_CTRL     = 8'h00;    // start, readback, chain length
    localparam logic [7:0]      OFS_STAT     = 8'h04;    // busy, done (write 1 clears)
    localparam logic [7:0]      OFS_TX0      = 8'h10;    // Outgoing word per device
    localparam logic [7:0]      OFS_RX0      = 8'h20;    // Returned word per device
    localparam int unsigned     CTRL_START   = 0;
    localparam int unsigned     CTRL_RDBK    = 1;
    localparam int unsigned     CTRL_LEN_LO  = 2;
    localparam int unsigned     STAT_BUSY    = 0;
    localparam int unsigned     STAT_DONE    = 1;
    localparam logic [1:0]      HTRANS_NSEQ  = 2'h2;

    // Sequencer states, Gray coded along the frame path
    typedef enum logic [2:0] {
        SRDC_IDLE  = 3'h0,
        SRDC_LOAD  = 3'h1,
        SRDC_LOW   = 3'h3,
        SRDC_HIGH  = 3'h2,
        SRDC_LATCH = 3'h6,
        SRDC_GAP   = 3'h7
    } srdc_state_t;

    // AHB-Lite request group as seen by the slave
    typedef struct packed {
        logic        sel;
        logic [31:0] addr;
        logic [1:0]  trans;
        logic        write;
        logic [2:0]  size;
        logic [31:0] wdata;
        logic        ready;
    } srdc_ahb_t;

    // Pins driven toward the converter chain
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic latch;
    } srdc_pins_t;

endpackage : srdc_pkg

// ---- testbench/srdc_host_assertions.sv ----
// Concurrent checks on the serial chain host pins and bus replies
`timescale 1ns/1ps
module srdc_host_assertions (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic SER_CLK,
    input wire logic SER_DOUT,
    input wire logic SER_LATCH
);
    logic       sclk_d_r;
    logic [6:0] rises_r;
    logic       count_ok;
    // Legal frame lengths are whole device words for one to four devices
    assign count_ok = rises_r inside {7'h18, 7'h30, 7'h48, 7'h60};
    // Count link clock rises since the last latch; cleared by the latch itself
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sclk_d_r <= 1'b0;
            rises_r  <= 7'h00;
        end else begin
            sclk_d_r <= SER_CLK;
            rises_r  <= SER_LATCH ? 7'h00 : rises_r + 7'(SER_CLK & ~sclk_d_r);
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_high;
        SER_CLK [*4] ##1 !SER_CLK;
    endsequence
    sequence s_pulse;
        (SER_LATCH && !SER_DOUT) [*4] ##1 !SER_LATCH;
    endsequence
    AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
        else $error("bus reply not okay");
    AST_CLK_HIGH: assert property ($rose(SER_CLK) |-> s_high)
        else $error("link clock high phase wrong");
    AST_CLK_LOW: assert property ($fell(SER_CLK) |-> !SER_CLK [*4])
        else $error("link clock low phase too short");
    AST_DOUT_SETUP: assert property ($rose(SER_CLK) |-> $stable(SER_DOUT))
        else $error("data moved at clock rise");
    AST_DOUT_HOLD: assert property (SER_CLK && $past(SER_CLK) |-> $stable(SER_DOUT))
        else $error("data moved while clock high");
    AST_LATCH_PULSE: assert property ($rose(SER_LATCH) |-> s_pulse)
        else $error("latch pulse shape wrong");
    AST_LATCH_COUNT: assert property ($rose(SER_LATCH) |-> count_ok)
        else $error("latch after wrong clock count");
    AST_LATCH_QUIET: assert property ($rose(SER_LATCH) |-> !SER_CLK [*8])
        else $error("clock ran during latch or gap");
endmodule : srdc_host_assertions

bind srdc_host srdc_host_assertions u_srdc_host_assertions (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .HREADYOUT (HREADYOUT),
    .HRESP     (HRESP),
    .SER_CLK   (SER_CLK),
    .SER_DOUT  (SER_DOUT),
    .SER_LATCH (SER_LATCH)
);

// ---- testbench/srdc_dev_model.sv ----
// Behavioural chain of up to four serial converters facing the host controller
`timescale 1ns/1ps
module srdc_dev_model #(
    parameter logic [15:0] STAT_VAL = 16'h0015   // Fixed fault_status pattern
) (
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       latch,
    input  wire logic [2:0] devs,
    output logic            miso,
    output int              frame_errs
);
    logic [23:0] sr [4] = '{default: 24'h000000};
    logic        so [4] = '{default: 1'b0};
    logic [15:0] rg [4][16] = '{default: '{default: 16'h0000}}; // Indexed by low command nibble
    int          rises = 0;
    // ------------------------------------------------------------
    // Readback select decode
    // ------------------------------------------------------------
    function automatic logic [15:0] pick(input int d, input logic [5:0] s);
        if (s[1:0] == 2'h0) return STAT_VAL;
        if (s[1:0] == 2'h1) return rg[d][4'h1];
        if (s[1:0] == 2'h2) return rg[d][4'h5];
        if (s == 6'h0B) return rg[d][4'h7];
        if (s == 6'h13) return rg[d][4'h8];
        if (s == 6'h17) return rg[d][4'h9];
        return 16'h0000;
    endfunction : pick
    initial frame_errs = 0;
    assign miso = so[devs - 3'h1];
    // Shift in on rises; each device feeds the next one's input
    always @(posedge sclk) begin
        rises <= rises + 1;
        for (int d = 0; d < 4; d++) sr[d] <= {sr[d][22:0], (d == 0) ? mosi : so[d - 1]};
    end
    // Output follows falling edges, top bit first, so stale contents pass on
    always @(negedge sclk) for (int d = 0; d < 4; d++) so[d] <= sr[d][23];
    // Every device commits together on the latch rise
    always @(posedge latch) begin
        if (rises != devs * 24) frame_errs++;
        rises = 0;
        for (int d = 0; d < 4; d++) begin
            case (sr[d][23:16])
                8'h01, 8'h55, 8'h57, 8'h58, 8'h59: rg[d][sr[d][19:16]] = sr[d][15:0];
                8'h02: begin
                    sr[d] = {8'h00, pick(d, sr[d][5:0])};
                    so[d] = 1'b0;
                end
                8'h56: if (sr[d][0]) rg[d][4'h5] = 16'h0000;
                default: ;
            endcase
        end
    end
endmodule : srdc_dev_model

// ---- testbench/srdc_host_tb_top.sv ----
// Bench for the serial chain host: bus tasks, chain runs and readback checks
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); fails++; end end
module srdc_host_tb_top;
    logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, sclk, mosi, latch, miso;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, devs;
    int          fails, comparisons, frame_errs;
    logic [7:0]  cmds [5] = '{8'h57, 8'h58, 8'h59, 8'h55, 8'h01};
    logic [15:0] vals [5] = '{16'h0A5A, 16'h8001, 16'h7FFE, 16'h1234, 16'hBEEF};
    logic [5:0]  sels [5] = '{6'h0B, 6'h13, 6'h17, 6'h3E, 6'h3D};
    initial clk = 1'b0;
    always #20 clk = ~clk;
    srdc_host u_srdc_host (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
        .SER_CLK(sclk), .SER_DOUT(mosi), .SER_LATCH(latch), .SER_DIN(miso));
    srdc_dev_model #(.STAT_VAL(16'h0015)) u_srdc_dev_model (.sclk(sclk), .mosi(mosi),
        .latch(latch), .devs(devs), .miso(miso), .frame_errs(frame_errs));
    // ------------------------------------------------------------
    // Bus and sequence tasks
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= srdc_pkg::HTRANS_NSEQ;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : bus
    // Start, poll until done under a bound, then clear done
    task automatic run(input logic [31:0] ctl);
        int n;
        bus(1'b1, srdc_pkg::OFS_CTRL, ctl | 32'h1);
        n = 0;
        rd = 32'h0;
        while (rd[srdc_pkg::STAT_DONE] !== 1'b1 && n < 2000) begin
            bus(1'b0, srdc_pkg::OFS_STAT, 32'h0);
            n++;
        end
        `CHECK("busy", 1'b0, rd[srdc_pkg::STAT_BUSY])
        `CHECK("done", 1'b1, rd[srdc_pkg::STAT_DONE])
        bus(1'b1, srdc_pkg::OFS_STAT, 32'h2);
    endtask : run
    task automatic tx(input int k, input logic [23:0] w);
        bus(1'b1, srdc_pkg::OFS_TX0 + 8'(4 * k), {8'h00, w});
    endtask : tx
    task automatic rx(input int k, input logic [23:0] w);
        bus(1'b0, srdc_pkg::OFS_RX0 + 8'(4 * k), 32'h0);
        `CHECK("rx_word", {8'h00, w}, rd)
    endtask : rx
    task automatic rdback(input logic [5:0] sel, input logic [15:0] exp);
        tx(0, {8'h00, 10'h000, sel});
        run(32'h2);
        rx(0, {8'h00, exp});
    endtask : rdback
    // Low select bits always 01, upper select bits vary per device
    function automatic logic [15:0] wv(input int n, input int k);
        return 16'hC001 | 16'(n << 8) | 16'(k << 4);
    endfunction : wv
    task automatic summarize();
        if (fails == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // Main sequence: reset, chains of one to four, then single device registers
    initial begin
        {rst_n, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        devs = 3'h1;
        fails = 0;
        comparisons = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, srdc_pkg::OFS_STAT, 32'h0);
        `CHECK("stat_reset", 32'h0, rd)
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        bus(1'b0, 8'h40, 32'h0);
        `CHECK("unmapped", 32'h0, rd)
        for (int n = 1; n <= 4; n++) begin
            devs <= 3'(n);
            for (int k = 0; k < n; k++) tx(k, {8'h01, wv(n, k)});
            run({28'h0, 2'(n - 1), 2'h0});
            run({28'h0, 2'(n - 1), 2'h0});
            for (int k = 0; k < n; k++) rx(k, {8'h01, wv(n, k)});
            run({28'h0, 2'(n - 1), 2'h2});
            for (int k = 0; k < n; k++) rx(k, {8'h00, wv(n, k)});
            bus(1'b0, srdc_pkg::OFS_CTRL, 32'h0);
            `CHECK("ctrl", {28'h0, 2'(n - 1), 2'h2}, rd)
        end
        devs <= 3'h1;
        foreach (cmds[i]) begin
            tx(0, {cmds[i], vals[i]});
            run(32'h0);
        end
        tx(0, 24'h00FFFF);
        run(32'h0);
        tx(0, 24'h95FFFF);
        run(32'h0);
        foreach (sels[i]) rdback(sels[i], vals[i]);
        rdback(6'h3C, 16'h0015);
        rdback(6'h03, 16'h0000);
        tx(0, 24'h560001);
        run(32'h0);
        rdback(6'h02, 16'h0000);
        `CHECK("frame_len", 0, frame_errs)
        summarize();
    end
    // Watchdog sized well past the expected run length
    initial begin
        #3000000;
        fails++;
        summarize();
    end
endmodule : srdc_host_tb_top
